//--- cpacr_regs.svh
// register offsets, field positions, reset values and serial-port constants for the clamp/power config bank
`ifndef CPACR_REGS_SVH
`define CPACR_REGS_SVH

// ----------------------------------------------------------------------------
// subaddresses
// ----------------------------------------------------------------------------
`define CPACR_OFS_LEVEL_FILTER   8'h28
`define CPACR_OFS_REQUIRED       8'h29
`define CPACR_OFS_FINE_CLAMP     8'h2A
`define CPACR_OFS_POWER_DOWN     8'h2B
`define CPACR_OFS_CONV_BIAS      8'h2C
`define CPACR_OFS_COARSE_CLAMP   8'h2D

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define CPACR_RST_LEVEL_FILTER   8'h03
`define CPACR_RST_REQUIRED       8'h08
`define CPACR_RST_FINE_CLAMP     8'h07
`define CPACR_RST_POWER_DOWN     8'h00
`define CPACR_RST_CONV_BIAS      8'h50
`define CPACR_RST_COARSE_CLAMP   8'h00
`define CPACR_UNMAPPED_READ      8'h00

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define CPACR_LEVEL_COEF_HI      2
`define CPACR_LEVEL_COEF_LO      0
`define CPACR_FINE_CM_SHIFT      7
`define CPACR_FINE_SWSEL_HI      4
`define CPACR_FINE_SWSEL_LO      3
`define CPACR_FINE_CLAMP_GB_EN            1
`define CPACR_FINE_R             0
`define CPACR_PD_SOG             6
`define CPACR_PD_SLICER          5
`define CPACR_PD_REF             4
`define CPACR_PD_CURRENT         3
`define CPACR_PD_CONV_BLUE       2
`define CPACR_PD_CONV_GREEN      1
`define CPACR_PD_CONV_RED        0
`define CPACR_CONV_BIAS_HI       7
`define CPACR_CONV_BIAS_LO       4
`define CPACR_CLAMP_BIAS_HI      3
`define CPACR_CLAMP_BIAS_LO      0
`define CPACR_COARSE_CHG_HI      7
`define CPACR_COARSE_CHG_LO      6
`define CPACR_COARSE_BLUE        2
`define CPACR_COARSE_GREEN       1
`define CPACR_COARSE_RED         0

// ----------------------------------------------------------------------------
// clamp bias arithmetic (microamps) and serial framing
// ----------------------------------------------------------------------------
`define CPACR_BIAS_BASE_UA       6'h02
`define CPACR_BIAS_STEP_UA       6'h02
`define CPACR_BITS_PER_BYTE      4'h8

`endif

//--- cpacr_pkg.sv
// types shared by the clamp/power config bank
`default_nettype none

package cpacr_pkg;
    typedef logic [7:0] cpacr_byte_t;

    typedef enum logic [3:0] {
        SER_IDLE,
        SER_DEV_ADDR,
        SER_DEV_ACK,
        SER_SUB_ADDR,
        SER_SUB_ACK,
        SER_WR_DATA,
        SER_WR_ACK,
        SER_RD_DATA,
        SER_RD_ACK
    } cpacr_ser_state_e;
endpackage

`default_nettype wire

//--- cpacr_reg_file.sv
// storage and read mux for subaddresses 28h..2Dh
`default_nettype none
`include "cpacr_regs.svh"

module cpacr_reg_file #(
    parameter int NUM_REGS = 6
) (
    input  wire logic                clock,
    input  wire logic                srst,
    input  wire logic                ce,
    input  wire logic                wrEn,
    input  wire cpacr_pkg::cpacr_byte_t addr,
    input  wire cpacr_pkg::cpacr_byte_t wrData,
    output cpacr_pkg::cpacr_byte_t   rdData,
    output cpacr_pkg::cpacr_byte_t   regLevel,
    output cpacr_pkg::cpacr_byte_t   regRequired,
    output cpacr_pkg::cpacr_byte_t   regFine,
    output cpacr_pkg::cpacr_byte_t   regPower,
    output cpacr_pkg::cpacr_byte_t   regConv,
    output cpacr_pkg::cpacr_byte_t   regCoarse
);
    import cpacr_pkg::*;

    localparam int IDX_W = $clog2(NUM_REGS);

    cpacr_byte_t regs      [NUM_REGS];
    cpacr_byte_t next_regs [NUM_REGS];

    // ------------------------------------------------------------------------
    // address decode
    // ------------------------------------------------------------------------
    function automatic logic regHit(input cpacr_byte_t a);
        regHit = (a >= `CPACR_OFS_LEVEL_FILTER) && (a <= `CPACR_OFS_COARSE_CLAMP);
    endfunction

    function automatic logic [IDX_W-1:0] regIdx(input cpacr_byte_t a);
        cpacr_byte_t diff;
        diff = a - `CPACR_OFS_LEVEL_FILTER;
        regIdx = diff[IDX_W-1:0];
    endfunction

    function automatic cpacr_byte_t resetValue(input int idx);
        case (idx)
            0:       resetValue = `CPACR_RST_LEVEL_FILTER;
            1:       resetValue = `CPACR_RST_REQUIRED;
            2:       resetValue = `CPACR_RST_FINE_CLAMP;
            3:       resetValue = `CPACR_RST_POWER_DOWN;
            4:       resetValue = `CPACR_RST_CONV_BIAS;
            default: resetValue = `CPACR_RST_COARSE_CLAMP;
        endcase
    endfunction

    // ------------------------------------------------------------------------
    // storage
    // ------------------------------------------------------------------------
    // all eight bits are stored, reserved ones too, so readback matches what was written
    always_comb begin
        for (int i = 0; i < NUM_REGS; i++) begin
            next_regs[i] = regs[i];
        end
        if (wrEn && regHit(addr)) begin
            next_regs[regIdx(addr)] = wrData;
        end
    end

    always_ff @(posedge clock) begin
        for (int i = 0; i < NUM_REGS; i++) begin
            if (srst) begin
                regs[i] <= resetValue(i);
            end else if (ce) begin
                regs[i] <= next_regs[i];
            end
        end
    end

    assign rdData      = regHit(addr) ? regs[regIdx(addr)] : `CPACR_UNMAPPED_READ;
    assign regLevel    = regs[0];
    assign regRequired = regs[1];
    assign regFine     = regs[2];
    assign regPower    = regs[3];
    assign regConv     = regs[4];
    assign regCoarse   = regs[5];
endmodule // cpacr_reg_file

`default_nettype wire

//--- cpacr_clamp_power_regs.sv
// clamp, power-down and converter bias configuration bank behind the host serial control port
//
// Overview of operation
// - three-bit level filter code picks coefficient 1/2..1/256; reset picks 1/16
// - fine clamp bit 7 enables the ~300 mV common-mode offset; reset off
// - common-mode offset ignored while coarse clamp active or mid-level clamp selected
// - two-bit fine time constant, 00 longest (reset) to 11 shortest
// - fine clamp bit 1 enables green and blue fine clamps; reset on
// - fine clamp bit 0 enables red fine clamp; reset on
// - power bits 6..3 power down sync-on-green, slicer, reference, current control
// - power bits 2..0 power down blue, green, red converters; reset active
// - upper bias nibble sets converter bias current, reset 5h
// - lower bias nibble sets clamp bias current 2+2*code microamps, reset 0h
// - coarse bits 7:6 pick charge current, 00 highest (reset), 11 lowest
// - coarse bits 2..0 enable blue, green, red coarse clamps; reset off
// - any coarse clamp enabled forces the fine clamps off
`default_nettype none
`include "cpacr_regs.svh"

module cpacr_clamp_power_regs #(
    parameter logic [6:0] DEV_ADDR = 7'h5D // arbitrary value, set per board
) (
    input  wire logic  clock,
    input  wire logic  srst,
    input  wire logic  ce,
    input  wire logic  scl,
    input  wire logic  sdaIn,
    output logic       sdaOut,
    output logic       sdaOe,
    input  wire logic  fineMidLevelSel,
    output logic [2:0] levelFilterCoef,
    output logic [3:0] levelFilterShift,
    output logic       commonModeShiftEn,
    output logic [1:0] fineSwSel,
    output logic       fineClampGbEn,
    output logic       fineClampREn,
    output logic       sogPd,
    output logic       slicerPd,
    output logic       refPd,
    output logic       currentCtlPd,
    output logic       convBluePd,
    output logic       convGreenPd,
    output logic       convRedPd,
    output logic [3:0] convBiasCtl,
    output logic [3:0] clampBiasCode,
    output logic [5:0] clampBiasCurrent,
    output logic [1:0] coarseChargeSel,
    output logic       coarseBlueEn,
    output logic       coarseGreenEn,
    output logic       coarseRedEn
);
    import cpacr_pkg::*;

    // ------------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------------
    logic sclMeta, sclSync, sclPrev;
    logic sdaMeta, sdaSync, sdaPrev;
    logic next_sclMeta, next_sclSync, next_sclPrev;
    logic next_sdaMeta, next_sdaSync, next_sdaPrev;

    always_comb begin
        next_sclMeta = scl;
        next_sclSync = sclMeta;
        next_sclPrev = sclSync;
        next_sdaMeta = sdaIn;
        next_sdaSync = sdaMeta;
        next_sdaPrev = sdaSync;
    end

    // idle bus is pulled high, so the chain resets high to avoid a false start
    always_ff @(posedge clock) begin
        if (srst) begin
            sclMeta <= 1'b1;
            sclSync <= 1'b1;
            sclPrev <= 1'b1;
            sdaMeta <= 1'b1;
            sdaSync <= 1'b1;
            sdaPrev <= 1'b1;
        end else if (ce) begin
            sclMeta <= next_sclMeta;
            sclSync <= next_sclSync;
            sclPrev <= next_sclPrev;
            sdaMeta <= next_sdaMeta;
            sdaSync <= next_sdaSync;
            sdaPrev <= next_sdaPrev;
        end
    end

    logic sclRise, sclFall, startCond, stopCond;
    assign sclRise   = sclSync & ~sclPrev;
    assign sclFall   = ~sclSync & sclPrev;
    assign startCond = sclSync & sclPrev & sdaPrev & ~sdaSync;
    assign stopCond  = sclSync & sclPrev & ~sdaPrev & sdaSync;

    // ------------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------------
    cpacr_byte_t subAddr, rdData, shiftReg;
    cpacr_byte_t regLevel, regRequired, regFine, regPower, regConv, regCoarse;
    logic        regWrite;

    cpacr_reg_file #(
        .NUM_REGS (6)
    ) u_reg_file (
        .clock       (clock),
        .srst        (srst),
        .ce          (ce),
        .wrEn        (regWrite),
        .addr        (subAddr),
        .wrData      (shiftReg),
        .rdData      (rdData),
        .regLevel    (regLevel),
        .regRequired (regRequired),
        .regFine     (regFine),
        .regPower    (regPower),
        .regConv     (regConv),
        .regCoarse   (regCoarse)
    );

    // ------------------------------------------------------------------------
    // serial port slave
    // ------------------------------------------------------------------------
    cpacr_ser_state_e state, next_state;
    logic [3:0]       bitCnt, next_bitCnt;
    cpacr_byte_t      next_shiftReg, next_subAddr;
    logic             readMode, next_readMode;
    logic             next_sdaOe;

    // sda only changes after scl falls, so the master always samples a settled bit
    always_comb begin
        next_state    = state;
        next_bitCnt   = bitCnt;
        next_shiftReg = shiftReg;
        next_subAddr  = subAddr;
        next_readMode = readMode;
        next_sdaOe    = sdaOe;
        regWrite      = 1'b0;
        if (startCond) begin
            next_state  = SER_DEV_ADDR;
            next_bitCnt = 4'h0;
            next_sdaOe  = 1'b0;
        end else if (stopCond) begin
            next_state = SER_IDLE;
            next_sdaOe = 1'b0;
        end else begin
            case (state)
                SER_IDLE: begin
                end
                SER_DEV_ADDR, SER_SUB_ADDR, SER_WR_DATA: begin
                    if (sclRise) begin
                        next_shiftReg = {shiftReg[6:0], sdaSync};
                        next_bitCnt   = 4'(bitCnt + 4'h1);
                    end else if (sclFall && bitCnt == `CPACR_BITS_PER_BYTE) begin
                        next_bitCnt = 4'h0;
                        next_sdaOe  = 1'b1;
                        if (state == SER_DEV_ADDR) begin
                            next_readMode = shiftReg[0];
                            next_state    = SER_DEV_ACK;
                            if (shiftReg[7:1] != DEV_ADDR) begin
                                next_state = SER_IDLE;
                                next_sdaOe = 1'b0;
                            end
                        end else if (state == SER_SUB_ADDR) begin
                            next_subAddr = shiftReg;
                            next_state   = SER_SUB_ACK;
                        end else begin
                            regWrite     = 1'b1;
                            next_subAddr = subAddr + 8'h01;
                            next_state   = SER_WR_ACK;
                        end
                    end
                end
                SER_DEV_ACK: begin
                    if (sclFall) begin
                        if (readMode) begin
                            next_shiftReg = rdData;
                            next_subAddr  = subAddr + 8'h01;
                            next_sdaOe    = ~rdData[7];
                            next_bitCnt   = 4'h1;
                            next_state    = SER_RD_DATA;
                        end else begin
                            next_sdaOe = 1'b0;
                            next_state = SER_SUB_ADDR;
                        end
                    end
                end
                SER_SUB_ACK, SER_WR_ACK: begin
                    if (sclFall) begin
                        next_sdaOe = 1'b0;
                        next_state = SER_WR_DATA;
                    end
                end
                SER_RD_DATA: begin
                    if (sclFall) begin
                        if (bitCnt == `CPACR_BITS_PER_BYTE) begin
                            next_sdaOe  = 1'b0;
                            next_bitCnt = 4'h0;
                            next_state  = SER_RD_ACK;
                        end else begin
                            next_shiftReg = {shiftReg[6:0], 1'b0};
                            next_sdaOe    = ~shiftReg[6];
                            next_bitCnt   = 4'(bitCnt + 4'h1);
                        end
                    end
                end
                SER_RD_ACK: begin
                    // master ack reuses the device-ack load path for the next byte
                    if (sclRise) begin
                        next_state = sdaSync ? SER_IDLE : SER_DEV_ACK;
                    end
                end
                default: begin
                    next_state = SER_IDLE;
                    next_sdaOe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            state    <= SER_IDLE;
            bitCnt   <= 4'h0;
            shiftReg <= 8'h00;
            subAddr  <= 8'h00;
            readMode <= 1'b0;
            sdaOe    <= 1'b0;
            sdaOut   <= 1'b0;
        end else if (ce) begin
            state    <= next_state;
            bitCnt   <= next_bitCnt;
            shiftReg <= next_shiftReg;
            subAddr  <= next_subAddr;
            readMode <= next_readMode;
            sdaOe    <= next_sdaOe;
            sdaOut   <= 1'b0;
        end
    end

    // ------------------------------------------------------------------------
    // analog front-end controls
    // ------------------------------------------------------------------------
    function automatic logic [5:0] biasMicroamps(input logic [3:0] code);
        biasMicroamps = `CPACR_BIAS_BASE_UA + 6'(`CPACR_BIAS_STEP_UA * {2'h0, code});
    endfunction

    logic       coarseAny;
    logic [2:0] next_levelFilterCoef;
    logic [3:0] next_levelFilterShift;
    logic       next_commonModeShiftEn, next_fineClampGbEn, next_fineClampREn;
    logic [1:0] next_fineSwSel, next_coarseChargeSel;
    logic [6:0] next_powerBits;
    logic [3:0] next_convBiasCtl, next_clampBiasCode;
    logic [5:0] next_clampBiasCurrent;
    logic [2:0] next_coarseEn;

    // outputs follow the registers one cycle later; the override costs no extra delay
    always_comb begin
        coarseAny             = |regCoarse[`CPACR_COARSE_BLUE:`CPACR_COARSE_RED];
        next_levelFilterCoef  = regLevel[`CPACR_LEVEL_COEF_HI:`CPACR_LEVEL_COEF_LO];
        next_levelFilterShift = 4'({1'b0, next_levelFilterCoef} + 4'h1);
        next_commonModeShiftEn = regFine[`CPACR_FINE_CM_SHIFT] & ~coarseAny & ~fineMidLevelSel;
        next_fineSwSel        = regFine[`CPACR_FINE_SWSEL_HI:`CPACR_FINE_SWSEL_LO];
        next_fineClampGbEn    = regFine[`CPACR_FINE_CLAMP_GB_EN] & ~coarseAny;
        next_fineClampREn     = regFine[`CPACR_FINE_R] & ~coarseAny;
        next_powerBits        = regPower[`CPACR_PD_SOG:`CPACR_PD_CONV_RED];
        next_convBiasCtl      = regConv[`CPACR_CONV_BIAS_HI:`CPACR_CONV_BIAS_LO];
        next_clampBiasCode    = regConv[`CPACR_CLAMP_BIAS_HI:`CPACR_CLAMP_BIAS_LO];
        next_clampBiasCurrent = biasMicroamps(next_clampBiasCode);
        next_coarseChargeSel  = regCoarse[`CPACR_COARSE_CHG_HI:`CPACR_COARSE_CHG_LO];
        next_coarseEn         = regCoarse[`CPACR_COARSE_BLUE:`CPACR_COARSE_RED];
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            levelFilterCoef   <= 3'h3;
            levelFilterShift  <= 4'h4;
            commonModeShiftEn <= 1'b0;
            fineSwSel         <= 2'h0;
            fineClampGbEn     <= 1'b1;
            fineClampREn      <= 1'b1;
            sogPd             <= 1'b0;
            slicerPd          <= 1'b0;
            refPd             <= 1'b0;
            currentCtlPd      <= 1'b0;
            convBluePd        <= 1'b0;
            convGreenPd       <= 1'b0;
            convRedPd         <= 1'b0;
            convBiasCtl       <= 4'h5;
            clampBiasCode     <= 4'h0;
            clampBiasCurrent  <= 6'h02;
            coarseChargeSel   <= 2'h0;
            coarseBlueEn      <= 1'b0;
            coarseGreenEn     <= 1'b0;
            coarseRedEn       <= 1'b0;
        end else if (ce) begin
            levelFilterCoef   <= next_levelFilterCoef;
            levelFilterShift  <= next_levelFilterShift;
            commonModeShiftEn <= next_commonModeShiftEn;
            fineSwSel         <= next_fineSwSel;
            fineClampGbEn     <= next_fineClampGbEn;
            fineClampREn      <= next_fineClampREn;
            sogPd             <= next_powerBits[6];
            slicerPd          <= next_powerBits[5];
            refPd             <= next_powerBits[4];
            currentCtlPd      <= next_powerBits[3];
            convBluePd        <= next_powerBits[2];
            convGreenPd       <= next_powerBits[1];
            convRedPd         <= next_powerBits[0];
            convBiasCtl       <= next_convBiasCtl;
            clampBiasCode     <= next_clampBiasCode;
            clampBiasCurrent  <= next_clampBiasCurrent;
            coarseChargeSel   <= next_coarseChargeSel;
            coarseBlueEn      <= next_coarseEn[2];
            coarseGreenEn     <= next_coarseEn[1];
            coarseRedEn       <= next_coarseEn[0];
        end
    end
endmodule // cpacr_clamp_power_regs

`default_nettype wire

//--- cpacr_host_model.sv
// host-side serial master model for the clamp/power config bank
`default_nettype none
module cpacr_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h5D // arbitrary value
) (
    input  wire logic clock,
    input  wire logic sdaWire,
    output logic      scl,
    output logic      hostPull
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl = 1'b1;
        hostPull = 1'b0;
    end
    // ----
    // bus phases, each held 8 clocks so the device synchronisers keep up
    // ----
    task automatic drive(input logic s, input logic p);
        scl <= s;
        hostPull <= p;
        repeat (8) @(posedge clock);
    endtask
    task automatic start();
        drive(0, 0);
        drive(1, 0);
        drive(1, 1);
        drive(0, 1);
    endtask
    task automatic stop();
        drive(0, 1);
        drive(1, 1);
        drive(1, 0);
    endtask
    // data moves mid-low so it never changes on the scl edge
    task automatic bitx(input logic b, output logic r);
        drive(0, ~b);
        drive(1, ~b);
        r = sdaWire;
        drive(0, ~b);
    endtask
    task automatic xbyte(input logic [7:0] d, output logic [7:0] q, output logic a);
        for (int i = 7; i >= 0; i--) bitx(d[i], q[i]);
        bitx(1'b1, a);
    endtask
    // ack result: 0 when every byte was acknowledged
    task automatic wr(input logic [6:0] dev, input logic [7:0] sub, d, output logic ack);
        logic [7:0] q;
        logic a1, a2, a3;
        start();
        xbyte({dev, 1'b0}, q, a1);
        xbyte(sub, q, a2);
        xbyte(d, q, a3);
        stop();
        ack = a1 | a2 | a3;
    endtask
    task automatic rd(input logic [7:0] sub, output logic [7:0] q, output logic ack);
        logic a1, a2, a3, n;
        start();
        xbyte({DEV_ADDR, 1'b0}, q, a1);
        xbyte(sub, q, a2);
        start();
        xbyte({DEV_ADDR, 1'b1}, q, a3);
        xbyte(8'hFF, q, n);
        stop();
        ack = a1 | a2 | a3;
    endtask
endmodule // cpacr_host_model
`default_nettype wire

//--- cpacr_clamp_power_regs_chk.sv
// port-level assertions for the clamp/power config bank
`default_nettype none
module cpacr_clamp_power_regs_chk (
    input wire logic       clock,
    input wire logic       srst,
    input wire logic       ce,
    input wire logic       scl,
    input wire logic       sdaOut,
    input wire logic       sdaOe,
    input wire logic       fineMidLevelSel,
    input wire logic [2:0] levelFilterCoef,
    input wire logic [3:0] levelFilterShift,
    input wire logic       commonModeShiftEn,
    input wire logic [1:0] fineSwSel,
    input wire logic       fineClampGbEn,
    input wire logic       fineClampREn,
    input wire logic       sogPd,
    input wire logic       convBluePd,
    input wire logic       convRedPd,
    input wire logic [3:0] convBiasCtl,
    input wire logic [3:0] clampBiasCode,
    input wire logic [5:0] clampBiasCurrent,
    input wire logic [1:0] coarseChargeSel,
    input wire logic       coarseBlueEn,
    input wire logic       coarseGreenEn,
    input wire logic       coarseRedEn
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);
    wire anyCoarse = coarseBlueEn | coarseGreenEn | coarseRedEn;
    wire [13:0] cfgv = {convBiasCtl, clampBiasCode, coarseChargeSel, fineSwSel, sogPd, convBluePd};
    sequence s_reset_left;
        $fell(srst);
    endsequence
    // a register write lands once per byte, so fields then sit still
    sequence s_settle;
        !scl ##1 $stable(cfgv)[*8];
    endsequence
    a_reset_outputs: assert property (s_reset_left |-> levelFilterCoef == 3'h3 && convBiasCtl == 4'h5
        && fineClampGbEn && fineClampREn && !sdaOe && clampBiasCode == 4'h0 && !anyCoarse && !convRedPd)
        else $error("outputs not at reset values");
    a_coarse_fine_off: assert property (anyCoarse |-> !fineClampGbEn && !fineClampREn && !commonModeShiftEn)
        else $error("fine clamp live under coarse clamp");
    // a frozen clock enable holds the old offset, so only a running cycle counts
    a_mid_drops_shift: assert property ($past(fineMidLevelSel) && $past(ce) |-> !commonModeShiftEn)
        else $error("offset active in mid-level mode");
    a_shift_tracks_code: assert property (levelFilterShift == {1'b0, levelFilterCoef} + 4'h1)
        else $error("filter shift mismatch");
    a_bias_sum: assert property (clampBiasCurrent == 6'h02 + {1'b0, clampBiasCode, 1'b0})
        else $error("clamp bias current mismatch");
    // a reset also moves the fields, with no write behind it
    a_cfg_settles: assert property (!$past(srst) && $changed(cfgv) |-> s_settle)
        else $error("config moved outside a write");
    a_ack_scl_low: assert property ($changed(sdaOe) |-> !scl)
        else $error("sda drive changed with scl high");
    a_sda_open_drain: assert property (sdaOut == 1'b0)
        else $error("sda driven high");
endmodule // cpacr_clamp_power_regs_chk
bind cpacr_clamp_power_regs cpacr_clamp_power_regs_chk chk (.*);
`default_nettype wire

//--- tb_cpacr_clamp_power_regs.sv
// self-checking bench for the clamp/power config bank
`default_nettype none
module tb_cpacr_clamp_power_regs;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, srst = 1'b1, fineMidLevelSel = 1'b0, ce = 1'b1;
    logic scl, hostPull, sdaOut, sdaOe, commonModeShiftEn, fineClampGbEn, fineClampREn, ack;
    logic sogPd, slicerPd, refPd, currentCtlPd, convBluePd, convGreenPd, convRedPd;
    logic coarseBlueEn, coarseGreenEn, coarseRedEn;
    logic [1:0] fineSwSel, coarseChargeSel;
    logic [2:0] levelFilterCoef;
    logic [3:0] levelFilterShift, convBiasCtl, clampBiasCode;
    logic [5:0] clampBiasCurrent;
    logic [7:0] q;
    int err_total = 0, num_checks = 0;
    // open drain with pull-up
    wire sdaWire = ~(sdaOe | hostPull);
    wire [7:0] pdv = {1'b0, sogPd, slicerPd, refPd, currentCtlPd, convBluePd, convGreenPd, convRedPd};
    wire [7:0] fcv = {commonModeShiftEn, 3'h0, fineSwSel, fineClampGbEn, fineClampREn};
    wire [7:0] ccv = {coarseChargeSel, 3'h0, coarseBlueEn, coarseGreenEn, coarseRedEn};
    always #2.5 clock = ~clock;
    cpacr_clamp_power_regs dut (.clock, .srst, .ce, .scl, .sdaIn(sdaWire), .sdaOut, .sdaOe,
        .fineMidLevelSel, .levelFilterCoef, .levelFilterShift, .commonModeShiftEn, .fineSwSel,
        .fineClampGbEn, .fineClampREn, .sogPd, .slicerPd, .refPd, .currentCtlPd, .convBluePd,
        .convGreenPd, .convRedPd, .convBiasCtl, .clampBiasCode, .clampBiasCurrent,
        .coarseChargeSel, .coarseBlueEn, .coarseGreenEn, .coarseRedEn);
    cpacr_host_model host (.clock, .sdaWire, .scl, .hostPull);
    task automatic chk(input logic [7:0] g, e);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wrc(input logic [7:0] sub, d);
        host.wr(7'h5D, sub, d, ack);
        chk({7'h0, ack}, 8'h00);
    endtask
    task automatic rdc(input logic [7:0] sub, e);
        host.rd(sub, q, ack);
        chk({7'h0, ack}, 8'h00);
        chk(q, e);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        repeat (4) @(posedge clock);
        rdc(8'h28, 8'h03);
        rdc(8'h29, 8'h08);
        rdc(8'h2A, 8'h07);
        rdc(8'h2B, 8'h00);
        rdc(8'h2C, 8'h50);
        rdc(8'h2D, 8'h00);
        chk(fcv, 8'h03);
        for (int c = 0; c < 8; c += 7) begin
            wrc(8'h28, 8'(c));
            chk({1'b0, levelFilterCoef, levelFilterShift}, {1'b0, 3'(c), 4'(c + 1)});
        end
        wrc(8'h2A, 8'h9F);
        chk(fcv, 8'h8F);
        rdc(8'h2A, 8'h9F);
        ce <= 1'b0;
        fineMidLevelSel <= 1'b1;
        repeat (3) @(posedge clock);
        chk(fcv, 8'h8F);
        ce <= 1'b1;
        repeat (3) @(posedge clock);
        chk(fcv, 8'h0F);
        fineMidLevelSel <= 1'b0;
        wrc(8'h2B, 8'h7F);
        chk(pdv, 8'h7F);
        wrc(8'h2B, 8'h80);
        chk(pdv, 8'h00);
        rdc(8'h2B, 8'h80);
        wrc(8'h2C, 8'h8F);
        chk({convBiasCtl, clampBiasCode}, 8'h8F);
        chk({2'h0, clampBiasCurrent}, 8'h20);
        for (int k = 0; k < 3; k++) begin
            wrc(8'h2D, {2'(k + 1), 3'h0, 3'(1 << k)});
            chk(ccv, {2'(k + 1), 3'h0, 3'(1 << k)});
            chk(fcv, 8'h0C);
        end
        wrc(8'h2D, 8'h00);
        chk(fcv, 8'h8F);
        wrc(8'h2E, 8'h55);
        rdc(8'h2E, 8'h00);
        host.wr(7'h2A, 8'h29, 8'h00, ack);
        chk({7'h0, ack}, 8'h01);
        rdc(8'h29, 8'h08);
        srst <= 1'b1;
        repeat (2) @(posedge clock);
        srst <= 1'b0;
        repeat (4) @(posedge clock);
        rdc(8'h2A, 8'h07);
        conclude();
    end
    // run needs about 20000 clocks
    initial begin
        repeat (60000) @(posedge clock);
        err_total++;
        conclude();
    end
endmodule // tb_cpacr_clamp_power_regs
`default_nettype wire
